// *** rtl/sifm_link_if.sv ***
// Symbol-level serial link and management bus between PHY and controller
`timescale 1ns/10ps
interface sifm_link_if;
	logic [7:0] p2m_sym;         // PHY to controller symbol
	logic       p2m_k;           // Symbol is a special code
	logic [7:0] m2p_sym;         // Controller to PHY symbol
	logic       m2p_k;           // Symbol is a special code
	logic       p2m_mb_valid;    // Management bus byte from PHY
	logic       p2m_mb_first;    // First byte of a message
	logic [7:0] p2m_mb_data;     // Management bus data from PHY
	logic       m2p_mb_valid;    // Management bus byte to PHY
	logic       m2p_mb_first;    // First byte of a message
	logic [7:0] m2p_mb_data;     // Management bus data to PHY
	logic       serial_powered;  // Serial link powered, traffic on it
	logic       ref_clock_request_n;  // PHY asks for reference clock
	logic       power_clock_good_n;   // Power and clock not yet good

	modport phy (output p2m_sym, p2m_k, p2m_mb_valid, p2m_mb_first,
		p2m_mb_data, serial_powered, ref_clock_request_n,
		input m2p_sym, m2p_k, m2p_mb_valid, m2p_mb_first, m2p_mb_data,
		power_clock_good_n);
	modport mac (input p2m_sym, p2m_k, p2m_mb_valid, p2m_mb_first,
		p2m_mb_data, serial_powered, ref_clock_request_n,
		output m2p_sym, m2p_k, m2p_mb_valid, m2p_mb_first, m2p_mb_data,
		power_clock_good_n);
endinterface

// *** rtl/sifm_mac_end.sv ***
// Controller end: APB registers, register requests, status acknowledge
`timescale 1ns/10ps
module sifm_mac_end import sifm_pkg::*; #(
	parameter int PORT_RATE_MBPS = LINK_RATE_MBPS
) (
	input  wire logic        clk,     // 250 MHz clock
	input  wire logic        nrst,    // Sync reset, low
	sifm_link_if.mac         lnk,     // Link to PHY
	input  wire logic        psel,    // APB select
	input  wire logic        penable, // APB access phase
	input  wire logic        pwrite,  // APB write
	input  wire logic [7:0]  paddr,   // APB byte address
	input  wire logic [31:0] pwdata,  // APB write data
	output logic [31:0]      prdata,  // APB read data
	output logic             pready,  // APB ready
	output logic             pslverr  // APB error, unmapped
);
	typedef struct packed {
		sifm_tx_t     tst;
		logic [2:0]   tpos;
		logic [31:0]  tmsg;
		logic [7:0]   tcrc;
		logic         tis_ack;
		logic [2:0]   rpos;
		logic [31:0]  rbuf;
		logic [7:0]   rcrc;
		logic [3:0]   sync_cnt;
		logic         pcg;
		logic         cmd_pend;
		logic [31:0]  cmd_msg;
		logic         busy;
		logic [15:0]  resp_data;
		logic         resp_valid;
		logic [15:0]  stat_bytes;
		logic         stat_seen;
		logic         ack_pend;
		logic [15:0]  ack_fields;
		logic [31:0]  prdata;
		logic         pslverr;
		logic [7:0]   sym;
		logic         k;
		logic         mb_valid;
		logic         mb_first;
		logic [7:0]   mb_data;
		logic         sel_serial;
	} sifm_mac_st_t;

	sifm_mac_st_t r;
	sifm_mac_st_t next_r;

	always_comb begin
		logic       byte_v;
		logic [7:0] in_b;
		logic [7:0] tb;
		logic [7:0] ctl;
		logic       wr_now;
		byte_v = 1'b0;
		in_b = 8'h00;
		tb = 8'h00;
		ctl = 8'h00;
		wr_now = psel & penable & pwrite;
		next_r = r;
		next_r.sel_serial = lnk.serial_powered;
		if (r.sel_serial != lnk.serial_powered) begin
			next_r.tst = SIFM_TX_IDLE;
			next_r.rpos = 3'h0;
			if (r.tst == SIFM_TX_SEND)
				next_r.cmd_pend = ~r.tis_ack | r.cmd_pend;
		end
		// Register reads are captured in the setup cycle
		if (psel && !penable) begin
			next_r.prdata = 32'h0000_0000;
			next_r.pslverr = 1'b0;
			if (paddr == OFS_CTRL)
				next_r.prdata[0] = r.pcg;
			else if (paddr == OFS_CMD)
				next_r.prdata = r.cmd_msg;
			else if (paddr == OFS_RESP)
				next_r.prdata = {14'h0, r.busy, r.resp_valid, r.resp_data};
			else if (paddr == OFS_STAT)
				next_r.prdata = {13'h0, r.stat_seen, r.sel_serial,
					r.sync_cnt == SYNC_IDLES, r.stat_bytes};
			else if (paddr == OFS_ACKF)
				next_r.prdata = {16'h0, r.ack_fields};
			else if (paddr == OFS_RATE)
				next_r.prdata = 32'(PORT_RATE_MBPS);
			else
				next_r.pslverr = 1'b1;
		end
		if (wr_now && paddr == OFS_CTRL)
			next_r.pcg = pwdata[0];
		if (wr_now && paddr == OFS_ACKF)
			next_r.ack_fields = pwdata[15:0];
		if (wr_now && paddr == OFS_CMD && !r.busy) begin
			next_r.busy = 1'b1;
			next_r.cmd_pend = 1'b1;
			next_r.resp_valid = 1'b0;
			next_r.cmd_msg = {2'b00, pwdata[26], pwdata[20:16],
				pwdata[26] ? pwdata[15:0] : 16'h0000,
				3'b000, pwdata[25:21]};
		end
		// Receiver mirrors the PHY end
		if (!r.sel_serial) begin
			next_r.sync_cnt = 4'h0;
			if (lnk.p2m_mb_valid) begin
				if (lnk.p2m_mb_first)
					next_r.rpos = 3'h1;
				byte_v = (next_r.rpos != 3'h0);
				in_b = lnk.p2m_mb_data;
			end
		end else if (lnk.p2m_k) begin
			if (lnk.p2m_sym == K28_5 && r.sync_cnt != SYNC_IDLES)
				next_r.sync_cnt = r.sync_cnt + 4'h1;
			else if (lnk.p2m_sym != K28_5 && lnk.p2m_sym != K28_1)
				next_r.sync_cnt = 4'h0;
			next_r.rpos = (lnk.p2m_sym == K28_1 &&
				r.sync_cnt == SYNC_IDLES) ? 3'h1 : 3'h0;
		end else begin
			byte_v = (r.rpos != 3'h0);
			in_b = lnk.p2m_sym;
		end
		if (byte_v) begin
			if (next_r.rpos == 3'h1)
				next_r.rcrc = sifm_crc8(CRC_INIT, in_b);
			else if (next_r.rpos != MSG_LAST)
				next_r.rcrc = sifm_crc8(r.rcrc, in_b);
			if (next_r.rpos != MSG_LAST) begin
				next_r.rbuf = {r.rbuf[23:0], in_b};
				next_r.rpos = next_r.rpos + 3'h1;
			end else begin
				next_r.rpos = 3'h0;
				ctl = r.rbuf[31:24];
				if (in_b == r.rcrc) begin
					if (!ctl[CTL_TYPE_BIT] && ctl[CTL_DIR_BIT]) begin
						next_r.resp_data = r.rbuf[23:8];
						next_r.resp_valid = 1'b1;
						next_r.busy = 1'b0;
					end else if (ctl == CTL_STATUS) begin
						next_r.stat_bytes = r.rbuf[23:8];
						next_r.stat_seen = 1'b1;
						next_r.ack_pend = 1'b1;
					end
				end
			end
		end
		next_r.sym = r.sel_serial ? K28_5 : 8'h00;
		next_r.k = r.sel_serial;
		next_r.mb_valid = 1'b0;
		next_r.mb_first = 1'b0;
		case (r.tst)
			SIFM_TX_IDLE: begin
				if (r.ack_pend) begin
					next_r.tst = SIFM_TX_SEND;
					next_r.tmsg = {CTL_ACK, r.ack_fields, RSVD_BYTE};
					next_r.tis_ack = 1'b1;
					next_r.ack_pend = 1'b0;
					next_r.tpos = 3'h0;
				end else if (r.cmd_pend) begin
					next_r.tst = SIFM_TX_SEND;
					next_r.tmsg = r.cmd_msg;
					next_r.tis_ack = 1'b0;
					next_r.cmd_pend = 1'b0;
					next_r.tpos = 3'h0;
				end
			end
			SIFM_TX_SEND: begin
				if (r.tpos == 3'h0) begin
					if (r.sel_serial)
						next_r.sym = K28_1;
					next_r.tcrc = CRC_INIT;
				end else begin
					tb = (r.tpos == MSG_LAST) ? r.tcrc : r.tmsg[31:24];
					next_r.tmsg = {r.tmsg[23:0], 8'h00};
					next_r.tcrc = sifm_crc8(r.tcrc, tb);
					if (r.sel_serial) begin
						next_r.sym = tb;
						next_r.k = 1'b0;
					end else begin
						next_r.mb_valid = 1'b1;
						next_r.mb_first = (r.tpos == 3'h1);
						next_r.mb_data = tb;
					end
				end
				next_r.tpos = r.tpos + 3'h1;
				if (r.tpos == MSG_LAST)
					next_r.tst = SIFM_TX_IDLE;
			end
			default: next_r.tst = SIFM_TX_IDLE;
		endcase
		// A pickup in the switch cycle is undone, so its message stays due
		if (r.sel_serial != lnk.serial_powered) begin
			next_r.tst = SIFM_TX_IDLE;
			next_r.cmd_pend = next_r.cmd_pend | r.cmd_pend;
			next_r.ack_pend = next_r.ack_pend | r.ack_pend;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			r <= '0;
		else
			r <= next_r;
	end

	assign lnk.m2p_sym = r.sym;
	assign lnk.m2p_k = r.k;
	assign lnk.m2p_mb_valid = r.mb_valid;
	assign lnk.m2p_mb_first = r.mb_first;
	assign lnk.m2p_mb_data = r.mb_data;
	assign lnk.power_clock_good_n = ~r.pcg;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr;
	assign pready = 1'b1;
endmodule // sifm_mac_end

// *** rtl/sifm_phy_end.sv ***
// PHY end: status reports, register access answers, link selection
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module sifm_phy_end import sifm_pkg::*; #(
	parameter int TMR_W = 16
) (
	input  wire logic             clk,            // 250 MHz clock
	input  wire logic             nrst,           // Sync reset, low
	sifm_link_if.phy              lnk,            // Link to controller
	input  wire logic             system_active,  // System in S0
	input  wire logic             host_wake,      // Host wake event
	input  wire logic             ei_req,         // Electrical idle req
	input  wire logic             txoff_req,      // Back-pressure req
	input  wire logic             k1_req,         // Light sleep req
	input  wire logic             reset_done,     // PHY reset complete
	input  wire logic             cable_disc,     // Cable disconnected
	input  wire logic             eth_link,       // Ethernet link up
	input  wire logic             full_duplex,    // Full duplex
	input  wire logic [1:0]       speed,          // Line speed code
	input  wire logic [TMR_W-1:0] status_period,  // Periodic, 0 = off
	input  wire logic [TMR_W-1:0] ack_timeout,    // Ack wait, cycles
	input  wire logic [15:0]      cfg_rdata,      // Register read data
	output logic                  cfg_valid,      // Register access
	output logic                  cfg_write,      // Access is a write
	output logic [4:0]            cfg_reg,        // Register address
	output logic [4:0]            cfg_phy,        // PHY address
	output logic [15:0]           cfg_wdata,      // Write data
	output logic                  rate_limit_10m, // Line held to 10M
	output logic                  link_synced     // Receiver in sync
);
	typedef struct packed {
		sifm_tx_t          tst;
		logic [2:0]        tpos;
		logic [31:0]       tmsg;
		logic [7:0]        tcrc;
		logic              tis_stat;
		logic [2:0]        rpos;
		logic [31:0]       rbuf;
		logic [7:0]        rcrc;
		logic [3:0]        sync_cnt;
		logic              sel_serial;
		logic              resp_pend;
		logic [31:0]       resp_msg;
		logic              stat_pend;
		logic              await_ack;
		logic [15:0]       last_stat;
		logic [TMR_W-1:0]  per_cnt;
		logic [TMR_W-1:0]  ack_cnt;
		logic              cfg_valid;
		logic              cfg_write;
		logic [4:0]        cfg_reg;
		logic [4:0]        cfg_phy;
		logic [15:0]       cfg_wdata;
		logic [7:0]        sym;
		logic              k;
		logic              mb_valid;
		logic              mb_first;
		logic [7:0]        mb_data;
		logic              clk_req_n;
	} sifm_phy_st_t;

	sifm_phy_st_t r;
	sifm_phy_st_t next_r;

	always_comb begin
		logic        serial_on;
		logic        byte_v;
		logic [7:0]  in_b;
		logic [7:0]  tb;
		logic [7:0]  ctl;
		logic [1:0]  spd;
		logic [15:0] cur;
		serial_on = system_active & ~lnk.power_clock_good_n;
		byte_v = 1'b0;
		in_b = 8'h00;
		tb = 8'h00;
		ctl = 8'h00;
		spd = SPD_10;
		cur = 16'h0000;
		next_r = r;
		next_r.cfg_valid = 1'b0;
		next_r.clk_req_n = ~system_active;
		next_r.sel_serial = serial_on;
		// Switch: drop the frame in flight and resend what is unacked
		if (r.sel_serial != serial_on) begin
			next_r.tst = SIFM_TX_IDLE;
			next_r.rpos = 3'h0;
			if (r.tst == SIFM_TX_SEND && !r.tis_stat)
				next_r.resp_pend = 1'b1;
			if (r.await_ack || (r.tst == SIFM_TX_SEND && r.tis_stat))
				next_r.stat_pend = 1'b1;
		end
		// Status bytes; reserved speed code is never reported
		spd = (speed == SPD_RSVD) ? SPD_10 : speed;
		cur[8+S0_WAKE_BIT]  = host_wake;
		cur[8+S0_EI_BIT]    = ei_req;
		cur[8+S0_TXOFF_BIT] = txoff_req;
		cur[8+S0_K1_BIT]    = k1_req;
		cur[S1_RST_BIT]     = reset_done;
		cur[S1_IRQ_BIT]     = 1'b0;
		cur[S1_IFLINK_BIT]  = r.sel_serial && r.sync_cnt == SYNC_IDLES;
		cur[S1_CABLE_BIT]   = cable_disc;
		cur[S1_LINK_BIT]    = eth_link;
		cur[S1_DUPLEX_BIT]  = full_duplex;
		cur[1:0]            = spd;
		if (cur != r.last_stat) begin
			next_r.stat_pend = 1'b1;
			next_r.last_stat = cur;
			next_r.per_cnt = status_period;
		end else if (status_period != '0) begin
			if (r.per_cnt <= TMR_W'(1)) begin
				next_r.stat_pend = 1'b1;
				next_r.per_cnt = status_period;
			end else begin
				next_r.per_cnt = r.per_cnt - TMR_W'(1);
			end
		end
		if (r.await_ack) begin
			if (r.ack_cnt <= TMR_W'(1)) begin
				next_r.stat_pend = 1'b1;
				next_r.ack_cnt = ack_timeout;
			end else begin
				next_r.ack_cnt = r.ack_cnt - TMR_W'(1);
			end
		end
		// Receiver: sync on idles, then frames start at K28.1
		if (!r.sel_serial) begin
			next_r.sync_cnt = 4'h0;
			if (lnk.m2p_mb_valid) begin
				if (lnk.m2p_mb_first)
					next_r.rpos = 3'h1;
				byte_v = (next_r.rpos != 3'h0);
				in_b = lnk.m2p_mb_data;
			end
		end else if (lnk.m2p_k) begin
			if (lnk.m2p_sym == K28_5 && r.sync_cnt != SYNC_IDLES)
				next_r.sync_cnt = r.sync_cnt + 4'h1;
			else if (lnk.m2p_sym != K28_5 && lnk.m2p_sym != K28_1)
				next_r.sync_cnt = 4'h0;
			next_r.rpos = (lnk.m2p_sym == K28_1 &&
				r.sync_cnt == SYNC_IDLES) ? 3'h1 : 3'h0;
		end else begin
			byte_v = (r.rpos != 3'h0);
			in_b = lnk.m2p_sym;
		end
		if (byte_v) begin
			if (next_r.rpos == 3'h1)
				next_r.rcrc = sifm_crc8(CRC_INIT, in_b);
			else if (next_r.rpos != MSG_LAST)
				next_r.rcrc = sifm_crc8(r.rcrc, in_b);
			if (next_r.rpos != MSG_LAST) begin
				next_r.rbuf = {r.rbuf[23:0], in_b};
				next_r.rpos = next_r.rpos + 3'h1;
			end else begin
				next_r.rpos = 3'h0;
				ctl = r.rbuf[31:24];
				if (in_b == r.rcrc) begin
					if (!ctl[CTL_TYPE_BIT] && !ctl[CTL_DIR_BIT]) begin
						next_r.cfg_valid = 1'b1;
						next_r.cfg_write = ctl[CTL_WR_BIT];
						next_r.cfg_reg = ctl[4:0];
						next_r.cfg_wdata = r.rbuf[23:8];
						next_r.cfg_phy = r.rbuf[4:0];
					end else if (ctl == CTL_ACK) begin
						next_r.await_ack = 1'b0;
					end
				end
			end
		end
		// Answer the access in the cycle the register port is strobed
		if (r.cfg_valid) begin
			next_r.resp_pend = 1'b1;
			next_r.resp_msg = {2'b01, r.cfg_write, r.cfg_reg,
				r.cfg_write ? r.cfg_wdata : cfg_rdata, RSVD_BYTE};
		end
		// Transmitter: K28.1, four bytes, CRC; idles in between
		next_r.sym = r.sel_serial ? K28_5 : 8'h00;
		next_r.k = r.sel_serial;
		next_r.mb_valid = 1'b0;
		next_r.mb_first = 1'b0;
		case (r.tst)
			SIFM_TX_IDLE: begin
				if (r.resp_pend && (r.cfg_valid == 1'b0)) begin
					next_r.tst = SIFM_TX_SEND;
					next_r.tmsg = r.resp_msg;
					next_r.tis_stat = 1'b0;
					next_r.resp_pend = 1'b0;
					next_r.tpos = 3'h0;
				end else if (r.stat_pend) begin
					next_r.tst = SIFM_TX_SEND;
					// Latest status, so a change in this cycle is not lost
					next_r.tmsg = {CTL_STATUS, next_r.last_stat,
						RSVD_BYTE};
					next_r.tis_stat = 1'b1;
					next_r.stat_pend = 1'b0;
					next_r.tpos = 3'h0;
				end
			end
			SIFM_TX_SEND: begin
				if (r.tpos == 3'h0) begin
					if (r.sel_serial)
						next_r.sym = K28_1;
					next_r.tcrc = CRC_INIT;
				end else begin
					tb = (r.tpos == MSG_LAST) ? r.tcrc : r.tmsg[31:24];
					next_r.tmsg = {r.tmsg[23:0], 8'h00};
					next_r.tcrc = sifm_crc8(r.tcrc, tb);
					if (r.sel_serial) begin
						next_r.sym = tb;
						next_r.k = 1'b0;
					end else begin
						next_r.mb_valid = 1'b1;
						next_r.mb_first = (r.tpos == 3'h1);
						next_r.mb_data = tb;
					end
				end
				next_r.tpos = r.tpos + 3'h1;
				if (r.tpos == MSG_LAST) begin
					next_r.tst = SIFM_TX_IDLE;
					if (r.tis_stat) begin
						next_r.await_ack = 1'b1;
						next_r.ack_cnt = ack_timeout;
					end
				end
			end
			default: next_r.tst = SIFM_TX_IDLE;
		endcase
		// A pickup in the switch cycle is undone, so its message stays due
		if (r.sel_serial != serial_on) begin
			next_r.tst = SIFM_TX_IDLE;
			next_r.resp_pend = next_r.resp_pend | r.resp_pend;
			next_r.stat_pend = next_r.stat_pend | r.stat_pend;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			r <= '0;
			r.clk_req_n <= 1'b1;
			r.last_stat <= STAT_RESET;
			r.tmsg <= MSG_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign lnk.p2m_sym = r.sym;
	assign lnk.p2m_k = r.k;
	assign lnk.p2m_mb_valid = r.mb_valid;
	assign lnk.p2m_mb_first = r.mb_first;
	assign lnk.p2m_mb_data = r.mb_data;
	assign lnk.serial_powered = r.sel_serial;
	assign lnk.ref_clock_request_n = r.clk_req_n;
	assign cfg_valid = r.cfg_valid;
	assign cfg_write = r.cfg_write;
	assign cfg_reg = r.cfg_reg;
	assign cfg_phy = r.cfg_phy;
	assign cfg_wdata = r.cfg_wdata;
	assign rate_limit_10m = ~r.sel_serial;
	assign link_synced = r.sync_cnt == SYNC_IDLES;
endmodule // sifm_phy_end

// *** rtl/sifm_pkg.sv ***
// Shared constants, types and CRC helper for the in-band message framer
// Notes on behaviour
// - Serial link when active, management bus otherwise
// - Low-power mode limits Ethernet rate to 10M
// - Serial link runs 1250 Mb/s both ways
// - 100 MHz ref clock, clock-good reset, clock request
// - Controller port rate preloaded, never detected
// - Link carries whole Ethernet frames, not bus packets
// - Idle symbols sent, receiver syncs on idles
// - Device originates only status, then awaits acknowledge
// - Unacked message resent after interconnect switch
// - K28.1 leads, CRC-8 over remaining bytes
// - Request control byte: 0,0,read/write,register address
// - Write data high then low; read sends zeros
// - Fourth request byte holds PHY address
// - Response echoes direction and address plus data
// - Reserved byte before CRC sent as zero
// - Status sent on change or periodic expiry
// - Status retransmitted when acknowledge times out
// - Status control byte is 80h
// - First status byte: wake, idle, txoff, sleep
// - Second status byte: reset, links, cable, duplex
// - Speed code 10/01/00, 11 reserved
// - Controller acknowledges with C0h plus own status
package sifm_pkg;
	localparam int          CLK_MHZ        = 250;
	localparam int          REF_CLK_MHZ    = 100;
	localparam int          LINK_RATE_MBPS = 1250;
	localparam int          LP_RATE_MBPS   = 10;
	localparam logic [7:0]  K28_1          = 8'h3C;
	localparam logic [7:0]  K28_5          = 8'hBC;
	localparam logic [7:0]  CRC_POLY       = 8'h07;
	localparam logic [7:0]  CRC_INIT       = 8'h00;
	localparam logic [7:0]  CTL_STATUS     = 8'h80;
	localparam logic [7:0]  CTL_ACK        = 8'hC0;
	localparam logic [7:0]  RSVD_BYTE      = 8'h00;
	localparam int          CTL_TYPE_BIT   = 7;
	localparam int          CTL_DIR_BIT    = 6;
	localparam int          CTL_WR_BIT     = 5;
	localparam int          S0_WAKE_BIT    = 5;
	localparam int          S0_EI_BIT      = 2;
	localparam int          S0_TXOFF_BIT   = 1;
	localparam int          S0_K1_BIT      = 0;
	localparam int          S1_RST_BIT     = 7;
	localparam int          S1_IRQ_BIT     = 6;
	localparam int          S1_IFLINK_BIT  = 5;
	localparam int          S1_CABLE_BIT   = 4;
	localparam int          S1_LINK_BIT    = 3;
	localparam int          S1_DUPLEX_BIT  = 2;
	localparam logic [1:0]  SPD_1000       = 2'b10;
	localparam logic [1:0]  SPD_100        = 2'b01;
	localparam logic [1:0]  SPD_10         = 2'b00;
	localparam logic [1:0]  SPD_RSVD       = 2'b11;
	localparam logic [2:0]  MSG_LAST       = 3'h5;
	localparam logic [3:0]  SYNC_IDLES     = 4'h4;
	localparam logic [31:0] MSG_RESET      = 32'h0000_0000;
	localparam logic [15:0] STAT_RESET     = 16'h0000;
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_CMD        = 8'h04;
	localparam logic [7:0]  OFS_RESP       = 8'h08;
	localparam logic [7:0]  OFS_STAT       = 8'h0C;
	localparam logic [7:0]  OFS_ACKF       = 8'h10;
	localparam logic [7:0]  OFS_RATE       = 8'h14;

	typedef enum logic {SIFM_TX_IDLE, SIFM_TX_SEND} sifm_tx_t;

	function automatic logic [7:0] sifm_crc8(input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] v;
		v = c ^ d;
		for (int i = 0; i < 8; i++) begin
			v = v[7] ? ({v[6:0], 1'b0} ^ CRC_POLY) : {v[6:0], 1'b0};
		end
		return v;
	endfunction
endpackage

// *** testbench/serdes_inband_message_framer_bench.sv ***
// Bench joining both framer ends over one link
`timescale 1ns/10ps
module serdes_inband_message_framer_bench import sifm_pkg::*;;
	logic        clk, nrst, sys_act, wake, ei, txoff, k1, rst_dn;
	logic        cable, eth, dup, psel, penable, pwrite, err;
	logic        cfg_valid, cfg_write, rate_10m, synced, pready, pslverr;
	logic [1:0]  spd;
	logic [4:0]  cfg_reg, cfg_phy;
	logic [7:0]  paddr;
	logic [15:0] cfg_rdata, cfg_wdata;
	logic [31:0] pwdata, prdata, rd;
	int          failures, n_compared, n_cfg;
	sifm_link_if lnk();
	sifm_phy_end u_sifm_phy_end (.clk(clk), .nrst(nrst), .lnk(lnk),
		.system_active(sys_act), .host_wake(wake), .ei_req(ei),
		.txoff_req(txoff), .k1_req(k1), .reset_done(rst_dn),
		.cable_disc(cable), .eth_link(eth), .full_duplex(dup), .speed(spd),
		.status_period(16'h0032), .ack_timeout(16'h0028),
		.cfg_rdata(cfg_rdata), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
		.cfg_reg(cfg_reg), .cfg_phy(cfg_phy), .cfg_wdata(cfg_wdata),
		.rate_limit_10m(rate_10m), .link_synced(synced));
	sifm_mac_end u_sifm_mac_end (.clk(clk), .nrst(nrst), .lnk(lnk),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	sifm_sva u_sifm_sva (.clk(clk), .nrst(nrst), .p2m_sym(lnk.p2m_sym),
		.p2m_k(lnk.p2m_k), .p2m_mb_valid(lnk.p2m_mb_valid),
		.p2m_mb_first(lnk.p2m_mb_first), .p2m_mb_data(lnk.p2m_mb_data),
		.serial_powered(lnk.serial_powered),
		.ref_clock_request_n(lnk.ref_clock_request_n));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Idle edge first so psel is never driven twice in one step
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic poll(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		int i;
		i = 0;
		apb(1'b0, a, 32'h0);
		while ((rd & m) !== e && i < 300) begin
			apb(1'b0, a, 32'h0);
			i++;
		end
		check(rd & m, e);
	endtask
	// Write a command, check its framed bytes, wait for the answer
	task automatic cmd(input logic [31:0] c, input logic [31:0] fr,
		input logic [31:0] rs);
		apb(1'b1, OFS_CMD, c);
		apb(1'b0, OFS_CMD, 32'h0);
		check(rd, fr);
		poll(OFS_RESP, 32'h0001FFFF, rs);
	endtask
	function automatic logic [31:0] st(input logic ser);
		return {13'h0, 1'b1, ser, ser, 2'b00, wake, 2'b00, ei, txoff, k1,
			rst_dn, 1'b0, ser, cable, eth, dup,
			(spd == SPD_RSVD) ? SPD_10 : spd};
	endfunction
	// Every register access pulse seen by the PHY's register port
	always @(posedge clk)
		if (cfg_valid === 1'b1)
			n_cfg++;
	initial begin
		repeat (60000) @(posedge clk);
		$display("unexpected at %0t: watchdog expired", $time);
		failures++;
		close_out;
	end
	initial begin
		failures = 0;
		n_compared = 0;
		n_cfg = 0;
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		{sys_act, wake, ei, txoff, k1, rst_dn} = 6'b100001;
		{cable, eth, dup, spd, cfg_rdata} = {5'h0, 16'h5AC3};
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h1);
		apb(1'b0, OFS_CTRL, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, OFS_RATE, 32'h0);
		check(rd, 32'(LINK_RATE_MBPS));
		apb(1'b0, 8'h18, 32'h0);
		check({rd[30:0], err}, 32'h1);
		apb(1'b1, OFS_ACKF, 32'h0000A55A);
		apb(1'b0, OFS_ACKF, 32'h0);
		check(rd, 32'h0000A55A);
		for (int i = 0; i < 4; i++) begin
			{wake, ei, txoff, k1} <= {i[0], i[1], ~i[0], i[1]};
			{cable, eth, dup, spd} <= {i[1], 1'b1, i[0], i[1:0]};
			@(posedge clk);
			poll(OFS_STAT, {13'h0, 3'b111, 16'hFFFF}, st(1'b1));
		end
		check(32'(synced), 32'h1);
		cmd(32'h04D3BEEF, 32'h33BEEF06, 32'h0001BEEF);
		check(32'({cfg_write, cfg_phy, cfg_reg, cfg_wdata}),
			{5'h0, 1'b1, 5'h06, 5'h13, 16'hBEEF});
		cmd(32'h00FFFFFF, 32'h1F000007, 32'h00015AC3);
		check(32'({cfg_write, cfg_phy, cfg_reg}), 32'h000000FF);
		sys_act <= 1'b0;
		eth <= 1'b0;
		@(posedge clk);
		poll(OFS_STAT, {13'h0, 3'b110, 16'hFFFF}, st(1'b0));
		check(32'(rate_10m), 32'h1);
		cmd(32'h0441C001, 32'h21C00102, 32'h0001C001);
		sys_act <= 1'b1;
		@(posedge clk);
		poll(OFS_STAT, {13'h0, 3'b111, 16'hFFFF}, st(1'b1));
		check(32'(rate_10m), 32'h0);
		check(n_cfg, 32'd3);
		close_out;
	end
endmodule // serdes_inband_message_framer_bench

// *** testbench/sifm_sva.sv ***
// Link checker for the in-band message framer
`timescale 1ns/10ps
module sifm_sva import sifm_pkg::*; (
	input wire logic       clk,                 // Clock
	input wire logic       nrst,                // Sync reset, low
	input wire logic [7:0] p2m_sym,             // PHY symbol
	input wire logic       p2m_k,               // Special code
	input wire logic       p2m_mb_valid,        // Bus byte valid
	input wire logic       p2m_mb_first,        // First bus byte
	input wire logic [7:0] p2m_mb_data,         // Bus byte
	input wire logic       serial_powered,      // Serial in use
	input wire logic       ref_clock_request_n  // Clock request
);
	logic [2:0] pos;
	logic [7:0] acc;
	function automatic logic [7:0] step(input logic [7:0] c, d);
		logic [7:0] v;
		v = c ^ d;
		for (int i = 0; i < 8; i++)
			v = v[7] ? {v[6:0], 1'b0} ^ CRC_POLY : {v[6:0], 1'b0};
		return v;
	endfunction
	// Own CRC so a shared slip cannot hide
	always_ff @(posedge clk) begin
		if (!nrst)
			pos <= 3'h0;
		else if (p2m_k && p2m_sym == K28_1)
			pos <= 3'h1;
		else if (pos != 3'h0)
			pos <= (pos == 3'h5 || p2m_k) ? 3'h0 : pos + 3'h1;
		acc <= (pos == 3'h0) ? CRC_INIT : step(acc, p2m_sym);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_start; p2m_k && p2m_sym == K28_1; endsequence
	sequence s_stat; s_start ##1 p2m_sym[7]; endsequence
	a_frame_len: assert property (s_start |=> !p2m_k [*5])
		else $error("frame cut short");
	a_ctl_kind: assert property (s_start |=>
		p2m_sym == CTL_STATUS || p2m_sym[7:6] == 2'b01)
		else $error("bad control byte");
	a_stat_first: assert property (s_stat |=> (p2m_sym & 8'hD8) == 8'h00)
		else $error("status byte0 stray bits");
	a_stat_speed: assert property (s_stat |=> ##1
		p2m_sym[1:0] != SPD_RSVD && !p2m_sym[6])
		else $error("status byte1 bad");
	a_rsvd_zero: assert property (s_start |-> ##4 p2m_sym == RSVD_BYTE)
		else $error("reserved byte not zero");
	a_crc_match: assert property (pos == 3'h5 && serial_powered &&
		$past(serial_powered, 5) |-> p2m_sym == acc)
		else $error("crc mismatch");
	a_off_quiet: assert property (!serial_powered &&
		!$past(serial_powered) |-> p2m_sym == 8'h00 && !p2m_k)
		else $error("symbols while serial off");
	a_mb_quiet: assert property (serial_powered &&
		$past(serial_powered) |-> !p2m_mb_valid)
		else $error("bus bytes while serial on");
	a_clk_req: assert property (serial_powered &&
		$past(serial_powered) |-> !ref_clock_request_n)
		else $error("clock not requested");
	a_mb_ctl: assert property (p2m_mb_valid && p2m_mb_first |->
		p2m_mb_data == CTL_STATUS || p2m_mb_data[7:6] == 2'b01)
		else $error("bad bus control byte");
endmodule // sifm_sva
